// ### design/pmmc_pkg.sv
// Constants and types for the media mode and line tuning control registers
package pmmc_pkg;
  // Register offsets in management space
  localparam logic [4:0] PMMC_ADDR_MODE = 5'h17;
  localparam logic [4:0] PMMC_ADDR_TUNE = 5'h18;
  localparam int PMMC_AW = 5;
  localparam int PMMC_DW = 16;

  // Field positions, media_mode_control
  localparam int PMMC_RSV_HI = 15;
  localparam int PMMC_RSV_LO = 14;
  localparam int PMMC_MAC_BIT = 12;
  localparam int PMMC_PREF_BIT = 11;
  localparam int PMMC_MODE_HI = 10;
  localparam int PMMC_MODE_LO = 8;
  localparam int PMMC_OVR_HI = 7;
  localparam int PMMC_OVR_LO = 6;
  localparam int PMMC_FELB_BIT = 3;
  localparam int PMMC_PEND_HI = 13;

  // Field positions, line_tuning_control
  localparam int PMMC_EDGE_HI = 15;
  localparam int PMMC_EDGE_LO = 13;
  localparam int PMMC_RPWR_BIT = 12;
  localparam int PMMC_JUMBO_HI = 5;
  localparam int PMMC_JUMBO_LO = 4;
  localparam int PMMC_CLB_BIT = 0;

  // Values after reset
  localparam logic [1:0] PMMC_RSV_RST = 2'h0;
  localparam logic [0:0] PMMC_MAC_RST = 1'h0;
  localparam logic [0:0] PMMC_PREF_RST = 1'h0;
  localparam logic [2:0] PMMC_MODE_RST = 3'h0;
  localparam logic [1:0] PMMC_OVR_RST = 2'h0;
  localparam logic [0:0] PMMC_FELB_RST = 1'h0;
  localparam logic [2:0] PMMC_EDGE_RST = 3'h0;
  localparam logic [0:0] PMMC_RPWR_RST = 1'h0;
  localparam logic [1:0] PMMC_JUMBO_RST = 2'h0;
  localparam logic [0:0] PMMC_CLB_RST = 1'h0;

  // Retention class of a field across software reset
  localparam logic [1:0] PMMC_KIND_PLAIN = 2'h0;
  localparam logic [1:0] PMMC_KIND_STICKY = 2'h1;
  localparam logic [1:0] PMMC_KIND_SUPER = 2'h2;

  // Media operating mode codes
  typedef enum logic [2:0] {
    PMMC_M_COPPER = 3'h0,
    PMMC_M_PXFER = 3'h1,
    PMMC_M_BX = 3'h2,
    PMMC_M_FX = 3'h3,
    PMMC_M_RSVD = 3'h4,
    PMMC_M_AUTO_PXFER = 3'h5,
    PMMC_M_AUTO_BX = 3'h6,
    PMMC_M_AUTO_FX = 3'h7
  } pmmc_mode_t;

  // Override codes
  localparam logic [1:0] PMMC_OVR_NORMAL = 2'h0;
  localparam logic [1:0] PMMC_OVR_SERDES = 2'h1;
  localparam logic [1:0] PMMC_OVR_COPPER = 2'h2;

  // Fiber protocol on the fiber pins
  localparam logic [1:0] PMMC_FIB_NONE = 2'h0;
  localparam logic [1:0] PMMC_FIB_PXFER = 2'h1;
  localparam logic [1:0] PMMC_FIB_BX = 2'h2;
  localparam logic [1:0] PMMC_FIB_FX = 2'h3;

  // Jumbo codes and length limits in bytes
  localparam logic [1:0] PMMC_J_STD = 2'h0;
  localparam logic [1:0] PMMC_J_9K = 2'h1;
  localparam logic [1:0] PMMC_J_12K = 2'h2;
  localparam logic [14:0] PMMC_LEN_1K5 = 15'h0600;
  localparam logic [14:0] PMMC_LEN_9K = 15'h2400;
  localparam logic [14:0] PMMC_LEN_12K = 15'h3000;
  localparam logic [14:0] PMMC_LEN_16K = 15'h4000;
endpackage

// ### design/pmmc_field.sv
// One control field with its software-reset retention class
`timescale 1ns/1ps
module pmmc_field #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0,
  parameter logic [1:0] KIND = 2'h0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_val,
  input wire logic sw_rst,
  input wire logic keep_sticky,
  output logic [W-1:0] q
);
  import pmmc_pkg::*;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // Write wins over a software reset in the same cycle
  always_comb
  begin
    nxt_q = q_ff;
    if (wr_en)
    begin
      nxt_q = wr_val;
    end
    else if (sw_rst)
    begin
      if (KIND == PMMC_KIND_PLAIN)
      begin
        nxt_q = RST;
      end
      else if (KIND == PMMC_KIND_STICKY && !keep_sticky)
      begin
        nxt_q = RST;
      end
      // Super-sticky holds regardless
    end
  end

  // Register only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q_ff <= RST;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule // pmmc_field

// ### design/pmmc_decode.sv
// Decodes active mode and override into media enables
`timescale 1ns/1ps
module pmmc_decode (
  input wire pmmc_pkg::pmmc_mode_t mode,
  input wire logic [1:0] ovr,
  output logic copper_en,
  output logic fiber_en,
  output logic auto_en,
  output logic [1:0] fiber_kind
);
  import pmmc_pkg::*;

  // Single-medium and automatic codes, then override
  always_comb
  begin
    copper_en = 1'b0;
    fiber_en = 1'b0;
    auto_en = 1'b0;
    fiber_kind = PMMC_FIB_NONE;
    case (mode)
      PMMC_M_COPPER: copper_en = 1'b1;
      PMMC_M_PXFER:
      begin
        fiber_en = 1'b1;
        fiber_kind = PMMC_FIB_PXFER;
      end
      PMMC_M_BX:
      begin
        fiber_en = 1'b1;
        fiber_kind = PMMC_FIB_BX;
      end
      PMMC_M_FX:
      begin
        fiber_en = 1'b1;
        fiber_kind = PMMC_FIB_FX;
      end
      PMMC_M_AUTO_PXFER, PMMC_M_AUTO_BX, PMMC_M_AUTO_FX:
      begin
        auto_en = 1'b1;
        copper_en = 1'b1;
        fiber_en = 1'b1;
        fiber_kind = (mode == PMMC_M_AUTO_PXFER) ? PMMC_FIB_PXFER :
                     (mode == PMMC_M_AUTO_BX) ? PMMC_FIB_BX : PMMC_FIB_FX;
      end
      default:
      begin
        // Reserved code: no medium enabled
        copper_en = 1'b0;
      end
    endcase
    // Override narrows automatic selection only
    if (auto_en && ovr == PMMC_OVR_SERDES)
    begin
      copper_en = 1'b0;
    end
    else if (auto_en && ovr == PMMC_OVR_COPPER)
    begin
      fiber_en = 1'b0;
    end
  end
endmodule // pmmc_decode

// ### design/pmmc_regs.sv
// Media mode and line tuning control register bank
`timescale 1ns/1ps
module pmmc_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [pmmc_pkg::PMMC_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [pmmc_pkg::PMMC_DW-1:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic sw_reset,
  input wire logic sticky_reset_en,
  input wire logic mac_sel_valid,
  input wire logic ref_ppm_60,
  input wire logic ref_ppm_70,
  output logic [pmmc_pkg::PMMC_DW-1:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic mac_1000bx_ff,
  output logic prefer_copper_ff,
  output logic copper_en_ff,
  output logic fiber_en_ff,
  output logic automatic_media_select_ff,
  output logic [1:0] fiber_kind_ff,
  output logic far_end_loop_ff,
  output logic conn_loop_ff,
  output logic [2:0] edge_rate_ff,
  output logic reduced_power_ff,
  output logic [14:0] jumbo_max_len_ff
);
  import pmmc_pkg::*;

  logic wr_mode;
  logic wr_tune;
  logic [1:0] rsv_q;
  logic [1:0] ovr_q;
  logic felb_q;
  logic [2:0] edge_q;
  logic rpwr_q;
  logic [1:0] jumbo_q;
  logic clb_q;
  logic [5:0] pend_ff;
  logic [5:0] nxt_pend;
  logic [5:0] act_ff;
  logic [5:0] nxt_act;
  logic [15:0] nxt_rd_data;
  logic nxt_rd_valid;
  logic dec_cu;
  logic dec_fi;
  logic dec_auto;
  logic [1:0] dec_kind;
  logic nxt_mac;
  logic [14:0] nxt_jlen;

  // Address decode of write strobes
  assign wr_mode = reg_wr && (reg_addr == PMMC_ADDR_MODE);
  assign wr_tune = reg_wr && (reg_addr == PMMC_ADDR_TUNE);

  // Reserved read/write bits 15:14, cleared on software reset
  pmmc_field #(.W(2), .RST(PMMC_RSV_RST), .KIND(PMMC_KIND_PLAIN)) u_rsv (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_mode),
    .wr_val(reg_wdata[PMMC_RSV_HI:PMMC_RSV_LO]),
    .sw_rst(sw_reset),
    .keep_sticky(sticky_reset_en),
    .q(rsv_q)
  );

  // Override field, not sticky
  pmmc_field #(.W(2), .RST(PMMC_OVR_RST), .KIND(PMMC_KIND_PLAIN)) u_ovr (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_mode),
    .wr_val(reg_wdata[PMMC_OVR_HI:PMMC_OVR_LO]),
    .sw_rst(sw_reset),
    .keep_sticky(sticky_reset_en),
    .q(ovr_q)
  );

  // Far-end loopback enable
  pmmc_field #(.W(1), .RST(PMMC_FELB_RST), .KIND(PMMC_KIND_PLAIN)) u_felb (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_mode),
    .wr_val(reg_wdata[PMMC_FELB_BIT]),
    .sw_rst(sw_reset),
    .keep_sticky(sticky_reset_en),
    .q(felb_q)
  );

  // Edge rate step, sticky
  pmmc_field #(.W(3), .RST(PMMC_EDGE_RST), .KIND(PMMC_KIND_STICKY)) u_edge (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_tune),
    .wr_val(reg_wdata[PMMC_EDGE_HI:PMMC_EDGE_LO]),
    .sw_rst(sw_reset),
    .keep_sticky(sticky_reset_en),
    .q(edge_q)
  );

  // Reduced power, sticky
  pmmc_field #(.W(1), .RST(PMMC_RPWR_RST), .KIND(PMMC_KIND_STICKY)) u_rpwr (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_tune),
    .wr_val(reg_wdata[PMMC_RPWR_BIT]),
    .sw_rst(sw_reset),
    .keep_sticky(sticky_reset_en),
    .q(rpwr_q)
  );

  // Jumbo length code, sticky
  pmmc_field #(.W(2), .RST(PMMC_JUMBO_RST), .KIND(PMMC_KIND_STICKY)) u_jumbo (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_tune),
    .wr_val(reg_wdata[PMMC_JUMBO_HI:PMMC_JUMBO_LO]),
    .sw_rst(sw_reset),
    .keep_sticky(sticky_reset_en),
    .q(jumbo_q)
  );

  // Connector loopback enable
  pmmc_field #(.W(1), .RST(PMMC_CLB_RST), .KIND(PMMC_KIND_PLAIN)) u_clb (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_tune),
    .wr_val(reg_wdata[PMMC_CLB_BIT]),
    .sw_rst(sw_reset),
    .keep_sticky(sticky_reset_en),
    .q(clb_q)
  );

  // Pending mode bits 13:8 only move to active on software reset.
  // Super-sticky: neither copy is cleared by software reset.
  always_comb
  begin
    nxt_pend = pend_ff;
    nxt_act = act_ff;
    if (wr_mode)
    begin
      nxt_pend = reg_wdata[PMMC_PEND_HI:PMMC_MODE_LO];
    end
    if (sw_reset)
    begin
      nxt_act = pend_ff;
    end
  end

  // Register only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_ff <= {1'b0, PMMC_MAC_RST, PMMC_PREF_RST, PMMC_MODE_RST};
      act_ff <= {1'b0, PMMC_MAC_RST, PMMC_PREF_RST, PMMC_MODE_RST};
    end
    else
    begin
      pend_ff <= nxt_pend;
      act_ff <= nxt_act;
    end
  end

  // Media enables from the active mode
  pmmc_decode u_dec (
    .mode(pmmc_mode_t'(act_ff[2:0])),
    .ovr(ovr_q),
    .copper_en(dec_cu),
    .fiber_en(dec_fi),
    .auto_en(dec_auto),
    .fiber_kind(dec_kind)
  );

  // Interface select counts only while mac_sel_valid is high
  assign nxt_mac = act_ff[PMMC_MAC_BIT-PMMC_MODE_LO] && mac_sel_valid;

  // Jumbo limit; 100 ppm figures unless reference is tighter
  always_comb
  begin
    case (jumbo_q)
      PMMC_J_9K: nxt_jlen = ref_ppm_60 ? PMMC_LEN_12K : PMMC_LEN_9K;
      PMMC_J_12K: nxt_jlen = ref_ppm_70 ? PMMC_LEN_16K : PMMC_LEN_12K;
      default: nxt_jlen = PMMC_LEN_1K5; // Reserved code falls back to standard
    endcase
  end

  // Read mux; mode bits show the active copy, unmapped reads zero
  always_comb
  begin
    nxt_rd_data = 16'h0000;
    nxt_rd_valid = reg_rd;
    if (reg_rd && reg_addr == PMMC_ADDR_MODE)
    begin
      nxt_rd_data[PMMC_RSV_HI:PMMC_RSV_LO] = rsv_q;
      nxt_rd_data[PMMC_PEND_HI:PMMC_MODE_LO] = act_ff;
      nxt_rd_data[PMMC_OVR_HI:PMMC_OVR_LO] = ovr_q;
      nxt_rd_data[PMMC_FELB_BIT] = felb_q;
    end
    else if (reg_rd && reg_addr == PMMC_ADDR_TUNE)
    begin
      nxt_rd_data[PMMC_EDGE_HI:PMMC_EDGE_LO] = edge_q;
      nxt_rd_data[PMMC_RPWR_BIT] = rpwr_q;
      nxt_rd_data[PMMC_JUMBO_HI:PMMC_JUMBO_LO] = jumbo_q;
      nxt_rd_data[PMMC_CLB_BIT] = clb_q;
    end
  end

  // Output flops; everything leaves the block registered
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
      mac_1000bx_ff <= 1'b0;
      prefer_copper_ff <= 1'b0;
      copper_en_ff <= 1'b1;
      fiber_en_ff <= 1'b0;
      automatic_media_select_ff <= 1'b0;
      fiber_kind_ff <= PMMC_FIB_NONE;
      far_end_loop_ff <= 1'b0;
      conn_loop_ff <= 1'b0;
      edge_rate_ff <= PMMC_EDGE_RST;
      reduced_power_ff <= 1'b0;
      jumbo_max_len_ff <= PMMC_LEN_1K5;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      mac_1000bx_ff <= nxt_mac;
      prefer_copper_ff <= act_ff[PMMC_PREF_BIT-PMMC_MODE_LO];
      copper_en_ff <= dec_cu;
      fiber_en_ff <= dec_fi;
      automatic_media_select_ff <= dec_auto;
      fiber_kind_ff <= dec_kind;
      far_end_loop_ff <= felb_q;
      conn_loop_ff <= clb_q;
      edge_rate_ff <= edge_q;
      reduced_power_ff <= rpwr_q;
      jumbo_max_len_ff <= nxt_jlen;
    end
  end

  // Checks
  sequence mode_write_s;
    wr_mode && !sw_reset;
  endsequence

  pend_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    mode_write_s ##1 !sw_reset |-> act_ff == $past(act_ff))
    else $error("active mode moved without software reset");
  act_load_a: assert property (@(posedge clk) disable iff (!nrst)
    sw_reset |=> act_ff == $past(pend_ff))
    else $error("active mode not loaded on software reset");
  rd_active_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == PMMC_ADDR_MODE |=> rd_data_ff[13:8] == $past(act_ff))
    else $error("mode read did not show active mode");
  super_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    sw_reset && !wr_mode |=> pend_ff == $past(pend_ff))
    else $error("super-sticky bits lost on software reset");
  sticky_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    sw_reset && sticky_reset_en && !wr_tune |=> edge_q == $past(edge_q) &&
    rpwr_q == $past(rpwr_q) && jumbo_q == $past(jumbo_q))
    else $error("sticky fields lost");
  sticky_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    sw_reset && !sticky_reset_en && !wr_tune |=> edge_q == PMMC_EDGE_RST &&
    rpwr_q == PMMC_RPWR_RST && jumbo_q == PMMC_JUMBO_RST)
    else $error("sticky fields not defaulted");
  mac_valid_a: assert property (@(posedge clk) disable iff (!nrst)
    !mac_sel_valid |=> !mac_1000bx_ff)
    else $error("interface select honoured while invalid");
  ovr_serdes_a: assert property (@(posedge clk) disable iff (!nrst)
    dec_auto && ovr_q == PMMC_OVR_SERDES |=> !copper_en_ff && fiber_en_ff)
    else $error("serdes override not applied");
  jumbo_len_a: assert property (@(posedge clk) disable iff (!nrst)
    jumbo_q == PMMC_J_12K && ref_ppm_70 |=> jumbo_max_len_ff == PMMC_LEN_16K)
    else $error("tight clock jumbo limit wrong");
  rd_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == PMMC_ADDR_TUNE |=> rd_data_ff[11:6] == 6'h00 &&
    rd_data_ff[3:1] == 3'h0)
    else $error("reserved bits read nonzero");

  // Media selection and interface follow the active copy; jumbo limit follows the tuning field
  cu_only_a: assert property (@(posedge clk) disable iff (!nrst)
    act_ff[2:0] == PMMC_M_COPPER |=> copper_en_ff && !fiber_en_ff)
    else $error("copper-only mode not applied");
  rsvd_mode_a: assert property (@(posedge clk) disable iff (!nrst)
    act_ff[2:0] == PMMC_M_RSVD |=> !copper_en_ff && !fiber_en_ff)
    else $error("reserved mode enabled a medium");
  auto_mode_a: assert property (@(posedge clk) disable iff (!nrst)
    act_ff[2] && act_ff[1:0] != 2'h0 |=> automatic_media_select_ff)
    else $error("automatic selection not enabled");
  ovr_copper_a: assert property (@(posedge clk) disable iff (!nrst)
    dec_auto && ovr_q == PMMC_OVR_COPPER |=> copper_en_ff && !fiber_en_ff)
    else $error("copper override not applied");
  mac_sel_a: assert property (@(posedge clk) disable iff (!nrst)
    act_ff[PMMC_MAC_BIT-PMMC_MODE_LO] && mac_sel_valid |=> mac_1000bx_ff)
    else $error("interface select not honoured");
  pref_cu_a: assert property (@(posedge clk) disable iff (!nrst)
    act_ff[PMMC_PREF_BIT-PMMC_MODE_LO] |=> prefer_copper_ff)
    else $error("copper preference not applied");
  jumbo_9k_a: assert property (@(posedge clk) disable iff (!nrst)
    jumbo_q == PMMC_J_9K && ref_ppm_60 |=> jumbo_max_len_ff == PMMC_LEN_12K)
    else $error("tight clock 9k limit wrong");
endmodule // pmmc_regs

// ### testbench/pmmc_station.sv
// Management station model driving the register strobe port
`timescale 1ns/1ps
module pmmc_station (
  input wire logic clk,
  output logic [4:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  output logic sw_reset,
  input wire logic [15:0] rd_data_ff,
  input wire logic rd_valid_ff
);
  // Idle bus levels before the first request
  initial
  begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
    sw_reset = 1'b0;
  end

  // One write strobe; idle bus shows inverted values so stale data cannot match
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Read strobe; the answer stands for the cycle after the taking edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = rd_data_ff;
    v = rd_valid_ff;
  endtask

  // Software reset pulse, issued to make a pending mode write active
  task automatic srst();
    @(negedge clk);
    sw_reset = 1'b1;
    @(negedge clk);
    sw_reset = 1'b0;
  endtask
endmodule // pmmc_station

// ### testbench/phy_media_mode_control_regs_bench.sv
// Self-checking bench for the media mode and line tuning register bank
`timescale 1ns/1ps
module phy_media_mode_control_regs_bench import pmmc_pkg::*;;
  logic clk, nrst, reg_wr, reg_rd, sw_reset, sticky_reset_en, mac_sel_valid;
  logic ref_ppm_60, ref_ppm_70, rd_valid_ff, mac_1000bx_ff, prefer_copper_ff;
  logic copper_en_ff, fiber_en_ff, automatic_media_select_ff, far_end_loop_ff;
  logic conn_loop_ff, reduced_power_ff, v;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, rd_data_ff, d;
  logic [1:0] fiber_kind_ff;
  logic [2:0] edge_rate_ff;
  logic [14:0] jumbo_max_len_ff;
  int fails = 0;
  int num_checks = 0;
  // Length limits per code: 100 ppm reference, 60 ppm only, 70 ppm only
  logic [15:0] jlen [3][4] = '{'{16'h0600, 16'h2400, 16'h3000, 16'h0600},
                               '{16'h0600, 16'h3000, 16'h3000, 16'h0600},
                               '{16'h0600, 16'h2400, 16'h4000, 16'h0600}};

  pmmc_regs pmmc_regs_i (.clk, .nrst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .sw_reset, .sticky_reset_en, .mac_sel_valid, .ref_ppm_60, .ref_ppm_70,
    .rd_data_ff, .rd_valid_ff, .mac_1000bx_ff, .prefer_copper_ff, .copper_en_ff,
    .fiber_en_ff, .automatic_media_select_ff, .fiber_kind_ff, .far_end_loop_ff,
    .conn_loop_ff, .edge_rate_ff, .reduced_power_ff, .jumbo_max_len_ff);

  pmmc_station pmmc_station_i (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .sw_reset, .rd_data_ff, .rd_valid_ff);

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compare one value and count it
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Read a register and compare the answer
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    pmmc_station_i.rd(a, d, v);
    chk("rd_valid", 16'(v), 16'h0001);
    chk("rd_data", d, exp);
  endtask

  // Derived outputs lag the field flop by one more cycle
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #(20 * 20000);
    fails++;
    summarize();
  end

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    sticky_reset_en = 1'b1;
    mac_sel_valid = 1'b1;
    ref_ppm_60 = 1'b0;
    ref_ppm_70 = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    rchk(PMMC_ADDR_MODE, 16'h0000);
    rchk(PMMC_ADDR_TUNE, 16'h0000);
    chk("copper_en", 16'(copper_en_ff), 16'h0001);
    chk("jumbo_len", 16'(jumbo_max_len_ff), 16'h0600);
    rchk(5'h05, 16'h0000);
    $display("test reset values done");

    // Mode bits held pending; other fields act at once
    pmmc_station_i.wr(PMMC_ADDR_MODE, 16'h1E48);
    settle();
    rchk(PMMC_ADDR_MODE, 16'h0048);
    chk("auto_sel", 16'(automatic_media_select_ff), 16'h0000);
    chk("far_loop", 16'(far_end_loop_ff), 16'h0001);
    pmmc_station_i.srst();
    settle();
    rchk(PMMC_ADDR_MODE, 16'h1E00);
    chk("mac_1000bx", 16'(mac_1000bx_ff), 16'h0001);
    chk("prefer_cu", 16'(prefer_copper_ff), 16'h0001);
    mac_sel_valid = 1'b0;
    settle();
    chk("mac_1000bx", 16'(mac_1000bx_ff), 16'h0000);
    mac_sel_valid = 1'b1;
    sticky_reset_en = 1'b0;
    pmmc_station_i.srst();
    settle();
    rchk(PMMC_ADDR_MODE, 16'h1E00);
    $display("test pending mode done");

    // Every media operating mode code
    for (int m = 0; m < 8; m++)
    begin
      pmmc_station_i.wr(PMMC_ADDR_MODE, 16'(m << 8));
      pmmc_station_i.srst();
      settle();
      chk("auto_sel", 16'(automatic_media_select_ff), 16'(m >= 5));
      chk("copper_en", 16'(copper_en_ff), 16'(m == 0 || m >= 5));
      chk("fiber_en", 16'(fiber_en_ff), 16'(m != 0 && m != 4));
      chk("fiber_kind", 16'(fiber_kind_ff), 16'(m % 4));
    end
    pmmc_station_i.wr(PMMC_ADDR_MODE, 16'h0740);
    settle();
    chk("copper_en", 16'(copper_en_ff), 16'h0000);
    chk("fiber_en", 16'(fiber_en_ff), 16'h0001);
    pmmc_station_i.wr(PMMC_ADDR_MODE, 16'h0780);
    settle();
    chk("copper_en", 16'(copper_en_ff), 16'h0001);
    chk("fiber_en", 16'(fiber_en_ff), 16'h0000);
    $display("test mode codes done");

    // Tuning fields, reserved bits read zero
    pmmc_station_i.wr(PMMC_ADDR_TUNE, 16'hFFFF);
    rchk(PMMC_ADDR_TUNE, 16'hF031);
    for (int p = 0; p < 3; p++)
      for (int j = 0; j < 4; j++)
      begin
        ref_ppm_60 = (p == 1);
        ref_ppm_70 = (p == 2);
        pmmc_station_i.wr(PMMC_ADDR_TUNE, 16'hD001 | 16'(j << 4));
        settle();
        chk("jumbo_len", 16'(jumbo_max_len_ff), jlen[p][j]);
      end
    pmmc_station_i.wr(PMMC_ADDR_TUNE, 16'hD021);
    settle();
    chk("edge_rate", 16'(edge_rate_ff), 16'h0006);
    chk("red_power", 16'(reduced_power_ff), 16'h0001);
    chk("conn_loop", 16'(conn_loop_ff), 16'h0001);
    $display("test tuning done");

    // Sticky retention with and without the enable
    sticky_reset_en = 1'b1;
    pmmc_station_i.srst();
    settle();
    rchk(PMMC_ADDR_TUNE, 16'hD020);
    sticky_reset_en = 1'b0;
    pmmc_station_i.srst();
    settle();
    rchk(PMMC_ADDR_TUNE, 16'h0000);
    chk("red_power", 16'(reduced_power_ff), 16'h0000);
    chk("jumbo_len", 16'(jumbo_max_len_ff), 16'h0600);
    rchk(PMMC_ADDR_MODE, 16'h0700);
    $display("test sticky done");
    summarize();
  end
endmodule // phy_media_mode_control_regs_bench
